// [rtl/sfs_status.sv]
// Purpose: Primary status register of a serial flash, with its serial read-out.
// Assumes: Host drives sclk and cs_n; an external engine runs program/erase.
// Notes: All pins are sampled by clk; sclk must be at most an eighth of clk.
// Function
// - Status read answered at any time
// - Status repeats while chip select low
// - Status read works in quad mode
// - Busy bit shows write cycle running
// - Latch bit gates writes and operations
// - Protect level written, blocks array writes
// - Level writes only outside hardware protection
// - Chip wipe only with zero protection
// - Boot lock protects selected boot area
// - Guard plus low pin freezes register
// - Guard pin ignored while pins disabled
// - Configuration mode shows alternate bit view
// - Top/bottom select written in configuration
// - Lock size selects sector or block
// - Pin disable and quad mode mask pins
// - Shared pin is pause or reset
// - Area lock set once, blocks writes
// - Busy flag shared with second register
// - Configuration bit two is reserved
// - Arm sets latch; completion clears it
// - Disarm clears latch and configuration mode
// - Volatile write skips latch and cycle
`timescale 1ns/10ps
module sfs_status #(
  parameter int NVW_CYC = sfs_pkg::NV_WRITE_CYC,
  parameter logic [7:0] CONFIG_ENTER_OP = sfs_pkg::OP_CONFIG_ENTER_DEF
) (
  input wire logic clk, // System clock, 25 MHz.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic sclk, // Serial clock pin from host.
  input wire logic cs_n, // Chip select pin, active low.
  input wire logic wp_n, // Write guard pin, active low.
  input wire logic [3:0] dq_i, // Data pins, input side.
  output logic [3:0] dq_o, // Data pins, output side.
  output logic [3:0] dq_oe, // Data pin output enables.
  input wire logic engine_busy, // Program/erase engine running.
  input wire logic engine_done, // Program/erase engine finished, pulse.
  output sfs_pkg::sfs_op_t op_req, // Accepted operation request, pulse.
  output sfs_pkg::sfs_prot_t prot, // Protection settings for the engine.
  output logic busy_flag, // Shared busy flag for second register.
  output logic guard_active, // Hardware protected mode in effect.
  output logic pause_en, // Shared pin acts as pause input.
  output logic reset_en // Shared pin acts as reset input.
);

  generate
    if (NVW_CYC < 1 || NVW_CYC > 65535) begin : g_bad_cyc
      $error("NVW_CYC out of range");
    end
  endgenerate

  // ===========================================================================
  // Pin synchronisation and edges
  logic sclk_s, cs_s, wp_s;
  logic [3:0] dq_s;
  logic sclk_d_r, cs_d_r;

  sfs_sync #(.W(7)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({sclk, cs_n, wp_n, dq_i}),
    .rst_val(7'h7f),
    .q({sclk_s, cs_s, wp_s, dq_s})
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_d_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;
  wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_s;
  wire cs_rise = cs_s & ~cs_d_r;

  // ===========================================================================
  // Register state
  sfs_pkg::sfs_state_t state_r, state_nxt;
  logic [2:0] bit_cnt_r, out_cnt_r;
  logic [7:0] in_sr_r, out_sr_r, cmd_r, data_r;
  logic cmd_ok_r, data_ok_r;
  logic quad_r, cfg_mode_r, wel_r, vol_en_r;
  logic [15:0] nvw_cnt_r;
  logic [7:0] pend_r;
  logic pend_cfg_r;
  logic guard_r, boot_r, tb_r, lsz_r, pin_dis_r, pause_restart_pin_select_r, area_lock_r;
  logic [3:0] level_r;
  logic [3:0] dq_o_r, dq_oe_r;
  sfs_pkg::sfs_op_t op_r;

  // ===========================================================================
  // Serial shift-in
  wire [3:0] step = quad_r ? 4'h4 : 4'h1;
  wire [3:0] bit_sum = {1'b0, bit_cnt_r} + step;
  wire byte_done = sclk_rise & bit_sum[3];
  wire [7:0] in_nxt = quad_r ? {in_sr_r[3:0], dq_s} : {in_sr_r[6:0], dq_s[0]};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sfs_pkg::S_CMD: begin
        if (byte_done) begin
          if (in_nxt == sfs_pkg::OP_STATUS_READ) begin
            state_nxt = sfs_pkg::S_READ;
          end else if (in_nxt == sfs_pkg::OP_STATUS_WRITE) begin
            state_nxt = sfs_pkg::S_WDATA;
          end else begin
            state_nxt = sfs_pkg::S_SKIP;
          end
        end
      end
      sfs_pkg::S_WDATA: begin
        if (byte_done) begin
          state_nxt = sfs_pkg::S_SKIP;
        end
      end
      sfs_pkg::S_READ: state_nxt = sfs_pkg::S_READ;
      sfs_pkg::S_SKIP: state_nxt = sfs_pkg::S_SKIP;
      default: state_nxt = sfs_pkg::S_CMD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst || cs_s) begin
      state_r <= sfs_pkg::S_CMD;
      bit_cnt_r <= 3'h0;
      in_sr_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (sclk_rise) begin
        bit_cnt_r <= bit_sum[2:0];
        in_sr_r <= in_nxt;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_r <= 8'h00;
      data_r <= 8'h00;
      cmd_ok_r <= 1'b0;
      data_ok_r <= 1'b0;
    end else if (cs_s) begin
      cmd_ok_r <= 1'b0;
      data_ok_r <= 1'b0;
    end else if (byte_done && state_r == sfs_pkg::S_CMD) begin
      cmd_r <= in_nxt;
      cmd_ok_r <= 1'b1;
    end else if (byte_done && state_r == sfs_pkg::S_WDATA) begin
      data_r <= in_nxt;
      data_ok_r <= 1'b1;
    end
  end

  // ===========================================================================
  // Status byte and derived controls
  wire nvw_busy = nvw_cnt_r != 16'h0000;
  assign busy_flag = engine_busy | nvw_busy;
  wire pin_fn_en = ~pin_dis_r & ~quad_r;
  wire hw_prot = guard_r & ~wp_s & pin_fn_en;
  assign guard_active = hw_prot;
  assign pause_en = pin_fn_en & ~pause_restart_pin_select_r;
  assign reset_en = pin_fn_en & pause_restart_pin_select_r;
  wire [7:0] stat_cfg = {area_lock_r, pin_dis_r, pause_restart_pin_select_r, lsz_r, tb_r, 1'b0, wel_r, busy_flag};
  wire [7:0] stat_norm = {guard_r, boot_r, level_r, wel_r, busy_flag};
  wire [7:0] stat_byte = cfg_mode_r ? stat_cfg : stat_norm;
  assign prot = '{level: level_r, boot_en: boot_r, top_bottom: tb_r,
                  lock_4k: lsz_r, area_lock: area_lock_r};

  // ===========================================================================
  // Serial shift-out
  wire read_fall = sclk_fall && state_r == sfs_pkg::S_READ;
  wire [7:0] out_src = out_cnt_r == 3'h0 ? stat_byte : out_sr_r;
  wire [7:0] out_shift = quad_r ? {out_src[3:0], 4'h0} : {out_src[6:0], 1'b0};
  wire [2:0] out_cnt_nxt = 3'(out_cnt_r + step[2:0]);

  always_ff @(posedge clk) begin
    if (!nrst || cs_s) begin
      out_cnt_r <= 3'h0;
      out_sr_r <= 8'h00;
      dq_o_r <= 4'h0;
      dq_oe_r <= 4'h0;
    end else if (read_fall) begin
      out_cnt_r <= out_cnt_nxt;
      out_sr_r <= out_shift;
      dq_o_r <= quad_r ? out_src[7:4] : {2'b00, out_src[7], 1'b0};
      dq_oe_r <= quad_r ? 4'hf : 4'h2;
    end
  end

  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;

  // ===========================================================================
  // Command execution at end of frame
  wire exec = cs_rise & cmd_ok_r;
  wire do_arm = exec && cmd_r == sfs_pkg::OP_WRITE_ARM;
  wire do_disarm = exec && cmd_r == sfs_pkg::OP_WRITE_DISARM;
  wire do_vol = exec && cmd_r == sfs_pkg::OP_VOLATILE_WRITE;
  wire do_cfg = exec && cmd_r == CONFIG_ENTER_OP;
  wire do_qin = exec && !quad_r && cmd_r == sfs_pkg::OP_QUAD_ENTER;
  wire do_qout = exec && quad_r && cmd_r == sfs_pkg::OP_QUAD_EXIT;
  wire is_status_write_cmd = exec && cmd_r == sfs_pkg::OP_STATUS_WRITE && data_ok_r;
  wire status_write_cmd_ok = is_status_write_cmd && (wel_r || vol_en_r) && !hw_prot && !busy_flag;
  wire wr_now = status_write_cmd_ok && vol_en_r;
  wire nv_start = status_write_cmd_ok && !vol_en_r;
  wire nv_end = nvw_cnt_r == 16'h0001;
  wire [7:0] wr_val = wr_now ? data_r : pend_r;
  wire wr_cfg = wr_now ? cfg_mode_r : pend_cfg_r;
  wire wr_apply = wr_now | nv_end;

  wire is_chip = cmd_r == sfs_pkg::OP_CHIP_WIPE_A || cmd_r == sfs_pkg::OP_CHIP_WIPE_B;
  wire is_op = cmd_r == sfs_pkg::OP_PAGE_WRITE || cmd_r == sfs_pkg::OP_QUAD_PAGE_WRITE ||
               cmd_r == sfs_pkg::OP_SMALL_WIPE || cmd_r == sfs_pkg::OP_LARGE_WIPE || is_chip;
  wire chip_ok = level_r == sfs_pkg::RST_LEVEL && !boot_r;
  wire op_go = exec && is_op && wel_r && !busy_flag && (!is_chip || chip_ok);
  sfs_pkg::sfs_kind_t op_kind;
  assign op_kind = is_chip ? sfs_pkg::K_CHIP_WIPE :
                   cmd_r == sfs_pkg::OP_PAGE_WRITE ? sfs_pkg::K_PAGE :
                   cmd_r == sfs_pkg::OP_QUAD_PAGE_WRITE ? sfs_pkg::K_QUAD_PAGE :
                   cmd_r == sfs_pkg::OP_SMALL_WIPE ? sfs_pkg::K_SMALL_WIPE :
                   sfs_pkg::K_LARGE_WIPE;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      op_r <= '{valid: 1'b0, kind: sfs_pkg::K_PAGE};
    end else begin
      op_r <= '{valid: op_go, kind: op_kind};
    end
  end
  assign op_req = op_r;

  // ===========================================================================
  // Modes and latch
  // clear on completion, arm wins
  wire wel_nxt = do_arm | (wel_r & ~do_disarm & ~nv_end & ~engine_done);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wel_r <= 1'b0;
      vol_en_r <= 1'b0;
      quad_r <= 1'b0;
      cfg_mode_r <= 1'b0;
    end else begin
      wel_r <= wel_nxt;
      if (exec) begin
        vol_en_r <= do_vol;
      end
      quad_r <= (quad_r | do_qin) & ~do_qout;
      cfg_mode_r <= (cfg_mode_r | do_cfg) & ~do_disarm;
    end
  end

  // ===========================================================================
  // Status write cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nvw_cnt_r <= 16'h0000;
      pend_r <= 8'h00;
      pend_cfg_r <= 1'b0;
    end else if (nv_start) begin
      nvw_cnt_r <= 16'(NVW_CYC);
      pend_r <= data_r;
      pend_cfg_r <= cfg_mode_r;
    end else if (nvw_busy) begin
      nvw_cnt_r <= nvw_cnt_r - 16'h0001;
    end
  end

  // busy and latch bits never loaded from data
  always_ff @(posedge clk) begin
    if (!nrst) begin
      guard_r <= sfs_pkg::RST_GUARD;
      boot_r <= sfs_pkg::RST_BOOT;
      level_r <= sfs_pkg::RST_LEVEL;
      tb_r <= sfs_pkg::RST_TOP_BOTTOM;
      lsz_r <= sfs_pkg::RST_LOCK_SIZE;
      pin_dis_r <= sfs_pkg::RST_PIN_DIS;
      pause_restart_pin_select_r <= sfs_pkg::RST_PAUSE_SEL;
      area_lock_r <= sfs_pkg::RST_AREA_LOCK;
    end else if (wr_apply && wr_cfg) begin
      area_lock_r <= area_lock_r | wr_val[sfs_pkg::BIT_AREA_LOCK];
      pin_dis_r <= wr_val[sfs_pkg::BIT_PIN_DIS];
      pause_restart_pin_select_r <= wr_val[sfs_pkg::BIT_PAUSE_SEL];
      lsz_r <= wr_val[sfs_pkg::BIT_LOCK_SIZE];
      tb_r <= wr_val[sfs_pkg::BIT_TOP_BOTTOM];
    end else if (wr_apply) begin
      guard_r <= wr_val[sfs_pkg::BIT_GUARD];
      boot_r <= wr_val[sfs_pkg::BIT_BOOT];
      level_r <= wr_val[sfs_pkg::BIT_LEVEL_HI:sfs_pkg::BIT_LEVEL_LO];
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_read_decode;
    state_r == sfs_pkg::S_CMD && byte_done && in_nxt == sfs_pkg::OP_STATUS_READ && !cs_s
      |=> state_r == sfs_pkg::S_READ;
  endproperty
  a_read_decode: assert property (p_read_decode) else $error("read not decoded");

  property p_repeat;
    read_fall && out_cnt_r == 3'h0 && !quad_r |=> dq_o[1] == $past(stat_byte[7]);
  endproperty
  a_repeat: assert property (p_repeat) else $error("status byte not restarted");

  property p_quad_out;
    read_fall && quad_r |=> dq_oe == 4'hf && dq_o == $past(out_src[7:4]);
  endproperty
  a_quad_out: assert property (p_quad_out) else $error("quad read-out wrong");

  sequence s_nv_begin;
    nv_start;
  endsequence
  property p_busy;
    s_nv_begin |=> busy_flag && stat_byte[0];
  endproperty
  a_busy: assert property (p_busy) else $error("busy missing in write cycle");

  property p_latch_gate;
    op_req.valid |-> $past(wel_r);
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("op without latch");

  property p_guard;
    is_status_write_cmd && hw_prot && !busy_flag |=> $stable(level_r) && $stable(guard_r);
  endproperty
  a_guard: assert property (p_guard) else $error("write under hardware guard");

  property p_chip;
    op_req.valid && op_req.kind == sfs_pkg::K_CHIP_WIPE |-> $past(level_r) == 4'h0 &&
      !$past(boot_r);
  endproperty
  a_chip: assert property (p_chip) else $error("chip wipe while protected");

  property p_area_once;
    area_lock_r |=> area_lock_r;
  endproperty
  a_area_once: assert property (p_area_once) else $error("area lock cleared");

  property p_latch_clear;
    engine_done && !do_arm |=> !wel_r;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch kept after done");

endmodule : sfs_status

// [rtl/sfs_pkg.sv]
// Purpose: Shared constants and types for the serial flash status register block.
// Assumes: Opcodes and bit positions as the device defines them.
// Notes: Timing counts are derived here from times in nanoseconds.
package sfs_pkg;

  // ===========================================================================
  // Opcodes
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ARM = 8'h06;
  localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
  localparam logic [7:0] OP_VOLATILE_WRITE = 8'h50;
  localparam logic [7:0] OP_QUAD_ENTER = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hff;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
  localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
  localparam logic [7:0] OP_LARGE_WIPE = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'h60;
  localparam logic [7:0] OP_CONFIG_ENTER_DEF = 8'h3a;

  // ===========================================================================
  // Status byte fields
  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_LEVEL_LO = 2;
  localparam int BIT_LEVEL_HI = 5;
  localparam int BIT_BOOT = 6;
  localparam int BIT_GUARD = 7;
  localparam int BIT_TOP_BOTTOM = 3;
  localparam int BIT_LOCK_SIZE = 4;
  localparam int BIT_PAUSE_SEL = 5;
  localparam int BIT_PIN_DIS = 6;
  localparam int BIT_AREA_LOCK = 7;

  // ===========================================================================
  // Reset values
  localparam logic [3:0] RST_LEVEL = 4'h0;
  localparam logic RST_GUARD = 1'b0;
  localparam logic RST_BOOT = 1'b0;
  localparam logic RST_TOP_BOTTOM = 1'b0;
  localparam logic RST_LOCK_SIZE = 1'b0;
  localparam logic RST_PIN_DIS = 1'b1;
  localparam logic RST_PAUSE_SEL = 1'b0;
  localparam logic RST_AREA_LOCK = 1'b0;

  // ===========================================================================
  // Timing
  localparam int CLK_NS = 40;
  localparam int NV_WRITE_NS = 2000;
  localparam int NV_WRITE_CYC = (NV_WRITE_NS + CLK_NS - 1) / CLK_NS;

  // ===========================================================================
  // Types
  typedef enum logic [3:0] {
    S_CMD = 4'b0001,
    S_READ = 4'b0010,
    S_WDATA = 4'b0100,
    S_SKIP = 4'b1000
  } sfs_state_t;

  typedef enum logic [2:0] {
    K_PAGE = 3'h0,
    K_QUAD_PAGE = 3'h1,
    K_SMALL_WIPE = 3'h2,
    K_LARGE_WIPE = 3'h3,
    K_CHIP_WIPE = 3'h4
  } sfs_kind_t;

  typedef struct packed {
    logic valid;
    sfs_kind_t kind;
  } sfs_op_t;

  typedef struct packed {
    logic [3:0] level;
    logic boot_en;
    logic top_bottom;
    logic lock_4k;
    logic area_lock;
  } sfs_prot_t;

endpackage : sfs_pkg

// [rtl/sfs_sync.sv]
// Purpose: Two flip-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module sfs_sync #(
  parameter int W = 7
) (
  input wire logic clk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic [W-1:0] d, // Asynchronous inputs.
  input wire logic [W-1:0] rst_val, // Constant level held during reset.
  output logic [W-1:0] q // Synchronised outputs.
);

  logic [W-1:0] meta_r;

  // ===========================================================================
  // Per-bit stages
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!nrst) begin
          meta_r[i] <= rst_val[i];
          q[i] <= rst_val[i];
        end else begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : sfs_sync

// [sim/sfs_host_model.sv]
// Purpose: Host-side serial controller model that frames commands for the status block.
// Assumes: Mode 0 framing with a serial clock period of eight system clocks.
// Notes: Quad framing follows the mode entry and exit opcodes that this model sends.
`timescale 1ns/10ps
module sfs_host_model (
  input wire logic clk, // System clock that paces the link.
  output logic sclk, // Serial clock to the device.
  output logic cs_n, // Chip select, active low.
  output logic [3:0] dq_i, // Data lines toward the device.
  input wire logic [3:0] dq_o // Data lines from the device.
);
  logic quad;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq_i = 4'h0;
    quad = 1'b0;
  end

  // ===========================================================================
  // Byte transfer
  // The answer is sampled late in the high phase, since it only moves after a falling edge.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    int nb;
    nb = quad ? 2 : 8;
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      sclk <= 1'b0;
      if (quad) dq_i <= tx[7-4*i -: 4];
      else dq_i <= {~dq_i[3:1], tx[7-i]};
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      rx = quad ? {rx[3:0], dq_o} : {rx[6:0], dq_o[1]};
    end
  endtask : xbyte

  // ===========================================================================
  // Frame
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                       input int n, output logic [7:0] r1, output logic [7:0] r2);
    logic [7:0] rx;
    logic [7:0] b [3];
    b[0] = b0;
    b[1] = b1;
    b[2] = b2;
    r1 = 8'h00;
    r2 = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int k = 0; k < n; k++) begin
      xbyte(b[k], rx);
      if (k == 1) r1 = rx;
      if (k == 2) r2 = rx;
    end
    @(posedge clk);
    sclk <= 1'b0;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    if (b0 == sfs_pkg::OP_QUAD_ENTER && !quad) quad = 1'b1;
    else if (b0 == sfs_pkg::OP_QUAD_EXIT && quad) quad = 1'b0;
    repeat (6) @(posedge clk);
  endtask : frame
endmodule : sfs_host_model

// [sim/tb_serial_flash_status_register.sv]
// Purpose: Self-checking bench for the status register block.
// Assumes: Host model frames commands; a small engine model answers operation requests.
// Notes: The nonvolatile write cycle is shortened to four clocks.
`timescale 1ns/10ps
module tb_serial_flash_status_register;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  logic engine_busy = 1'b0;
  logic engine_done = 1'b0;
  logic sclk, cs_n, busy_flag, guard_active, pause_en, reset_en, seen;
  logic [3:0] dq_i, dq_o, dq_oe;
  logic [7:0] r1, r2;
  sfs_pkg::sfs_op_t op_req;
  sfs_pkg::sfs_prot_t prot;
  sfs_pkg::sfs_kind_t last_kind = sfs_pkg::K_PAGE;
  int ops = 0;
  int eng_cnt = 0;
  int error_cnt = 0;
  int tests_run = 0;
  logic [7:0] op_tbl [4] = '{sfs_pkg::OP_PAGE_WRITE, sfs_pkg::OP_QUAD_PAGE_WRITE,
                             sfs_pkg::OP_SMALL_WIPE, sfs_pkg::OP_LARGE_WIPE};

  always #20 clk = ~clk;

  sfs_status #(.NVW_CYC(4)) dut (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .wp_n(wp_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .engine_busy(engine_busy),
    .engine_done(engine_done), .op_req(op_req), .prot(prot), .busy_flag(busy_flag),
    .guard_active(guard_active), .pause_en(pause_en), .reset_en(reset_en));

  sfs_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o));

  // ===========================================================================
  // Engine model
  // Long enough that a full status read fits inside one operation.
  always @(posedge clk) begin
    engine_done <= (eng_cnt == 1);
    engine_busy <= (op_req.valid === 1'b1) || (eng_cnt > 1);
    if (op_req.valid === 1'b1) begin
      eng_cnt <= 300;
      ops <= ops + 1;
      last_kind <= op_req.kind;
    end else if (eng_cnt != 0) begin
      eng_cnt <= eng_cnt - 1;
    end
  end

  // ===========================================================================
  // Tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic idle(output logic s);
    s = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (busy_flag === 1'b1) s = 1'b1;
      if (i > 12 && busy_flag === 1'b0) return;
    end
    error_cnt++;
    report_and_stop();
  endtask : idle

  task automatic cmd(input logic [7:0] op);
    host.frame(op, 8'h00, 8'h00, 1, r1, r2);
  endtask : cmd

  task automatic wr(input logic [7:0] d, input logic vol);
    if (vol) cmd(sfs_pkg::OP_VOLATILE_WRITE);
    host.frame(sfs_pkg::OP_STATUS_WRITE, d, 8'h00, 2, r1, r2);
    idle(seen);
  endtask : wr

  task automatic rd_chk(input logic [7:0] exp);
    host.frame(sfs_pkg::OP_STATUS_READ, 8'h5a, 8'ha5, 3, r1, r2);
    check(r1, exp);
    check(r2, exp);
  endtask : rd_chk

  function automatic logic [7:0] pins();
    return {5'h00, guard_active, pause_en, reset_en};
  endfunction : pins

  // ===========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check(prot, 8'h00);
    check(pins(), 8'h00);
    rd_chk(8'h00);
    wr(8'h3c, 1'b0);
    cmd(sfs_pkg::OP_SMALL_WIPE);
    idle(seen);
    rd_chk(8'h00);
    check(8'(ops), 8'h00);
    cmd(sfs_pkg::OP_WRITE_ARM);
    rd_chk(8'h02);
    wr(8'h3f, 1'b0);
    check({7'h00, seen}, 8'h01);
    rd_chk(8'h3c);
    check({4'h0, prot.level}, 8'h0f);
    cmd(sfs_pkg::OP_WRITE_ARM);
    cmd(sfs_pkg::OP_CHIP_WIPE_A);
    idle(seen);
    check(8'(ops), 8'h00);
    for (int k = 0; k < 4; k++) begin
      cmd(sfs_pkg::OP_WRITE_ARM);
      cmd(op_tbl[k]);
      idle(seen);
      check({5'h00, last_kind}, 8'(k));
    end
    cmd(sfs_pkg::OP_WRITE_ARM);
    wr(8'h00, 1'b0);
    cmd(sfs_pkg::OP_WRITE_ARM);
    cmd(sfs_pkg::OP_CHIP_WIPE_B);
    rd_chk(8'h03);
    check({7'h00, busy_flag}, 8'h01);
    idle(seen);
    rd_chk(8'h00);
    check({5'h00, last_kind}, 8'h04);
    wr(8'h40, 1'b1);
    check(prot, 8'h08);
    cmd(sfs_pkg::OP_WRITE_ARM);
    cmd(sfs_pkg::OP_CHIP_WIPE_A);
    idle(seen);
    check(8'(ops), 8'h05);
    rd_chk(8'h42);
    cmd(sfs_pkg::OP_WRITE_DISARM);
    wr(8'h0c, 1'b1);
    rd_chk(8'h0c);
    wr(8'h80, 1'b1);
    wp_n <= 1'b0;
    repeat (4) @(posedge clk);
    check(pins(), 8'h00);
    wr(8'h84, 1'b1);
    rd_chk(8'h84);
    cmd(sfs_pkg::OP_CONFIG_ENTER_DEF);
    rd_chk(8'h40);
    // Pins stay disabled until the last write, since the guard then freezes the register.
    wr(8'h7c, 1'b1);
    rd_chk(8'h78);
    check(prot, 8'h16);
    wr(8'hf8, 1'b1);
    wr(8'h38, 1'b1);
    rd_chk(8'hb8);
    check(prot, 8'h17);
    cmd(sfs_pkg::OP_WRITE_DISARM);
    rd_chk(8'h84);
    check(pins(), 8'h05);
    wr(8'h00, 1'b1);
    rd_chk(8'h84);
    cmd(sfs_pkg::OP_QUAD_ENTER);
    check(pins(), 8'h00);
    rd_chk(8'h84);
    cmd(sfs_pkg::OP_QUAD_EXIT);
    check(pins(), 8'h05);
    wp_n <= 1'b1;
    wr(8'h00, 1'b1);
    rd_chk(8'h00);
    report_and_stop();
  end
endmodule : tb_serial_flash_status_register
